// >>> rtl/acq_config_pkg.sv
// constants, field layouts and carrier types of the acquisition config block
// assumes a single 100 MHz clock and a same-clock register access port
//
// Notes on behaviour
// - reference bit 0 is ratiometric on bias voltage, 1 is absolute 2.307V.
// - the same bit picks the threshold set used for that channel.
// - io mode masks the reference bit; readback shows the written value.
// - settle time is settle count times 6 us, zero by default.
// - settling starts every scan; auto bias drives during acquisition.
// - charge pump refreshes while settling when no other measurement runs.
// - stuck diagnostic runs after each ADC sequence (config not 010).
// - zero-scale alert unless result 0x000, full-scale alert unless 0xFFF.
// - calibration apply bit steers ADC results only, not comparator work.
// - accuracy diagnostic runs after comparator sequences (config 001 or 010).
// - unexpected accuracy result raises high or low alert per threshold.
// - rate code 00 feature driven, 01 gives 1.60 kHz, 1x gives 1.92 kHz.
// - selected rate applies only while oversample count is above zero.
// - code 00 samples as fast as the selected work allows.
// - bias mode 0x automatic, 10 always off, 11 always on.

package acq_config_pkg;

   // register offsets on the serial register port
   localparam logic [7:0] AUX_REFERENCE_CONTROL_ADDR = 8'h60;
   localparam logic [7:0] AUX_SETTLE_TIME_ADDR = 8'h61;
   localparam logic [7:0] ACQUISITION_CONFIG_ADDR = 8'h62;

   // field layout
   localparam int AUX_CHANNELS = 6;
   localparam int SETTLE_COUNT_WIDTH = 10;
   localparam int STUCK_DIAG_BIT = 15;
   localparam int CAL_APPLY_BIT = 14;
   localparam int ACCURACY_DIAG_BIT = 13;
   localparam int RATE_SELECT_MSB = 12;
   localparam int RATE_SELECT_LSB = 11;
   localparam int BIAS_MODE_MSB = 10;
   localparam int BIAS_MODE_LSB = 9;
   localparam logic [15:0] REF_CONTROL_MASK = 16'h003F;
   localparam logic [15:0] SETTLE_TIME_MASK = 16'h03FF;
   localparam logic [15:0] ACQ_CONFIG_MASK = 16'hFE00;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;

   // codes
   localparam logic [2:0] SCAN_COMPARATOR_ONLY = 3'h2;
   localparam logic [2:0] SCAN_ADC_AND_COMPARATOR = 3'h1;
   localparam logic [2:0] OVERSAMPLE_OFF = 3'h0;
   localparam logic [1:0] RATE_CODE_FEATURES = 2'h0;
   localparam logic [1:0] RATE_CODE_1P60 = 2'h1;
   localparam logic [1:0] BIAS_MODE_OFF = 2'h2;
   localparam logic [1:0] BIAS_MODE_ON = 2'h3;
   localparam logic [11:0] ZERO_SCALE_EXPECT = 12'h000;
   localparam logic [11:0] FULL_SCALE_EXPECT = 12'hFFF;

   // timing: one settle step in ns, clock period in ns
   localparam int SETTLE_STEP_NS = 6000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_STEP_CYCLES = SETTLE_STEP_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0]
   {
      RATE_FASTEST,
      RATE_1P60_KHZ,
      RATE_1P92_KHZ
   } rate_type;

   // one register access on the serial register port
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } reg_req_type;

   // end-of-sequence diagnostic results from the analog front end
   typedef struct packed
   {
      logic stuck_valid;
      logic [11:0] zero_scale;
      logic [11:0] full_scale;
      logic accuracy_valid;
      logic accuracy_high_trip;
      logic accuracy_low_trip;
   } diag_result_type;

endpackage

// >>> rtl/settle_timer.sv
// settling interval timer: step prescaler plus down-counter of steps
// assumes load is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module settle_timer
#(
   parameter int COUNT_WIDTH = 10,
   parameter int STEP_CYCLES = 600
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [COUNT_WIDTH-1:0] count_i,
   output logic busy_o,
   output logic done_o
);

   localparam int PW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
   localparam logic [PW-1:0] PRE_RELOAD = PW'(STEP_CYCLES - 1);
   localparam logic [PW-1:0] PRE_ZERO = '0;
   localparam logic [COUNT_WIDTH-1:0] STEPS_ZERO = '0;
   localparam logic [COUNT_WIDTH-1:0] STEPS_ONE = COUNT_WIDTH'(1);

   logic [PW-1:0] pre;
   logic [COUNT_WIDTH-1:0] steps;
   logic next_busy;
   logic next_done;
   logic [PW-1:0] next_pre;
   logic [COUNT_WIDTH-1:0] next_steps;

   // load, then count whole steps down to zero
   always_comb
   begin
      next_busy = busy_o;
      next_done = 1'b0;
      next_pre = pre;
      next_steps = steps;
      if (load_i)
      begin
         next_busy = 1'b1;
         next_pre = PRE_RELOAD;
         next_steps = count_i;
      end
      else if (busy_o)
      begin
         if (steps == STEPS_ZERO)
         begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
         else if (pre == PRE_ZERO)
         begin
            next_pre = PRE_RELOAD;
            next_steps = steps - STEPS_ONE;
         end
         else
         begin
            next_pre = pre - PW'(1);
         end
      end
   end

   // state registers, frozen while ce is low
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         pre <= '0;
         steps <= '0;
      end
      else if (ce_i)
      begin
         busy_o <= next_busy;
         done_o <= next_done;
         pre <= next_pre;
         steps <= next_steps;
      end
   end

endmodule

`default_nettype wire

// >>> rtl/acquisition_config_control.sv
// acquisition configuration registers and their steering of the sequencer
// assumes register port and sequencer signals share CLK_I with this block
`timescale 1ns/1ps
`default_nettype none

module acquisition_config_control
#(
   parameter int STEP_CYCLES = acq_config_pkg::SETTLE_STEP_CYCLES
)
(
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic CE_I,
   input wire acq_config_pkg::reg_req_type REG_REQ_I,
   output logic [15:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   input wire logic SCAN_REQ_I,
   input wire logic [2:0] SCAN_SEQUENCE_CONFIG_I,
   input wire logic SEQ_END_I,
   input wire logic OTHER_MEAS_ACTIVE_I,
   input wire logic [5:0] AUX_PIN_IO_MODE_ENABLE_I,
   input wire logic [2:0] OVERSAMPLE_COUNT_I,
   input wire acq_config_pkg::diag_result_type DIAG_RESULT_I,
   output logic [5:0] AUX_ABS_REFERENCE_O,
   output logic SETTLE_DONE_O,
   output logic HIGH_VOLTAGE_CHARGE_PUMP_REFRESH_O,
   output logic THERMISTOR_BIAS_OUTPUT_ON_O,
   output logic CALIBRATION_APPLY_O,
   output var acq_config_pkg::rate_type OVERSAMPLE_RATE_O,
   output logic ADC_STUCK_DIAG_RUN_O,
   output logic COMPARATOR_ACCURACY_DIAG_RUN_O,
   output logic ADC_ZERO_SCALE_ALERT_O,
   output logic ADC_FULL_SCALE_ALERT_O,
   output logic COMPARATOR_ACCURACY_HIGH_ALERT_O,
   output logic COMPARATOR_ACCURACY_LOW_ALERT_O
);

   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_SETTLE,
      ST_CONVERT
   } seq_state_type;

   logic [15:0] aux_reference_control;
   logic [15:0] aux_settle_time;
   logic [15:0] acquisition_config;
   logic [15:0] next_ref;
   logic [15:0] next_settle;
   logic [15:0] next_acq;
   logic [15:0] next_rdata;
   logic next_rvalid;
   seq_state_type state;
   seq_state_type next_state;
   logic timer_load;
   logic timer_busy;
   logic timer_done;
   logic uses_adc;
   logic uses_comparator;
   logic [1:0] bias_mode;
   logic [1:0] rate_code;
   logic next_settle_done;
   logic next_refresh;
   logic next_bias_on;
   logic next_stuck_run;
   logic next_acc_run;
   logic next_zs_alert;
   logic next_fs_alert;
   logic next_high_alert;
   logic next_low_alert;
   logic [5:0] next_abs_ref;
   acq_config_pkg::rate_type next_rate;

   // software writes, masked to the implemented fields
   always_comb
   begin
      next_ref = aux_reference_control;
      next_settle = aux_settle_time;
      next_acq = acquisition_config;
      if (REG_REQ_I.wr)
      begin
         case (REG_REQ_I.addr)
            acq_config_pkg::AUX_REFERENCE_CONTROL_ADDR:
               next_ref = REG_REQ_I.wdata & acq_config_pkg::REF_CONTROL_MASK;
            acq_config_pkg::AUX_SETTLE_TIME_ADDR:
               next_settle = REG_REQ_I.wdata &
                             acq_config_pkg::SETTLE_TIME_MASK;
            acq_config_pkg::ACQUISITION_CONFIG_ADDR:
               next_acq = REG_REQ_I.wdata & acq_config_pkg::ACQ_CONFIG_MASK;
            default:
               next_ref = aux_reference_control;
         endcase
      end
   end

   // reads return stored values even where io mode masks them
   always_comb
   begin
      next_rvalid = REG_REQ_I.rd;
      next_rdata = REG_RDATA_O;
      if (REG_REQ_I.rd)
      begin
         case (REG_REQ_I.addr)
            acq_config_pkg::AUX_REFERENCE_CONTROL_ADDR:
               next_rdata = aux_reference_control;
            acq_config_pkg::AUX_SETTLE_TIME_ADDR:
               next_rdata = aux_settle_time;
            acq_config_pkg::ACQUISITION_CONFIG_ADDR:
               next_rdata = acquisition_config;
            default:
               next_rdata = acq_config_pkg::UNMAPPED_READ;
         endcase
      end
   end

   // register file and read port
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         aux_reference_control <= acq_config_pkg::REG_RESET;
         aux_settle_time <= acq_config_pkg::REG_RESET;
         acquisition_config <= acq_config_pkg::REG_RESET;
         REG_RDATA_O <= acq_config_pkg::REG_RESET;
         REG_RVALID_O <= 1'b0;
      end
      else if (CE_I)
      begin
         aux_reference_control <= next_ref;
         aux_settle_time <= next_settle;
         acquisition_config <= next_acq;
         REG_RDATA_O <= next_rdata;
         REG_RVALID_O <= next_rvalid;
      end
   end

   // field decode and scan classification
   assign bias_mode = acquisition_config[acq_config_pkg::BIAS_MODE_MSB:
                                         acq_config_pkg::BIAS_MODE_LSB];
   assign rate_code = acquisition_config[acq_config_pkg::RATE_SELECT_MSB:
                                         acq_config_pkg::RATE_SELECT_LSB];
   assign uses_adc = SCAN_SEQUENCE_CONFIG_I !=
                     acq_config_pkg::SCAN_COMPARATOR_ONLY;
   assign uses_comparator =
      (SCAN_SEQUENCE_CONFIG_I == acq_config_pkg::SCAN_ADC_AND_COMPARATOR) ||
      (SCAN_SEQUENCE_CONFIG_I == acq_config_pkg::SCAN_COMPARATOR_ONLY);
   assign timer_load = (state == ST_IDLE) && SCAN_REQ_I;

   // settling interval counter
   settle_timer
   #(
      .COUNT_WIDTH(acq_config_pkg::SETTLE_COUNT_WIDTH),
      .STEP_CYCLES(STEP_CYCLES)
   )
   u_settle_timer
   (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .ce_i(CE_I),
      .load_i(timer_load),
      .count_i(aux_settle_time[acq_config_pkg::SETTLE_COUNT_WIDTH-1:0]),
      .busy_o(timer_busy),
      .done_o(timer_done)
   );

   // scan sequence steps and the outputs they steer
   always_comb
   begin
      next_state = state;
      next_settle_done = 1'b0;
      next_stuck_run = 1'b0;
      next_acc_run = 1'b0;
      case (state)
         ST_IDLE:
            if (SCAN_REQ_I)
            begin
               next_state = ST_SETTLE;
            end
         ST_SETTLE:
            if (timer_done)
            begin
               next_state = ST_CONVERT;
               next_settle_done = 1'b1;
            end
         ST_CONVERT:
            if (SEQ_END_I)
            begin
               next_state = ST_IDLE;
               next_stuck_run =
                  acquisition_config[acq_config_pkg::STUCK_DIAG_BIT] &&
                  uses_adc;
               next_acc_run =
                  acquisition_config[acq_config_pkg::ACCURACY_DIAG_BIT] &&
                  uses_comparator;
            end
         default:
            next_state = ST_IDLE;
      endcase
      // refresh while settling with the measurement path idle
      next_refresh = (state == ST_SETTLE) && timer_busy &&
                     !OTHER_MEAS_ACTIVE_I;
      // bias switch: manual modes win, auto follows acquisition
      if (bias_mode == acq_config_pkg::BIAS_MODE_OFF)
         next_bias_on = 1'b0;
      else if (bias_mode == acq_config_pkg::BIAS_MODE_ON)
         next_bias_on = 1'b1;
      else
         next_bias_on = (next_state != ST_IDLE);
      // io mode channels fall back to ratiometric; bit n is channel n
      next_abs_ref = aux_reference_control[acq_config_pkg::AUX_CHANNELS-1:0] &
                     ~AUX_PIN_IO_MODE_ENABLE_I;
      // rate selection only matters when oversampling
      if (OVERSAMPLE_COUNT_I == acq_config_pkg::OVERSAMPLE_OFF)
         next_rate = acq_config_pkg::RATE_FASTEST;
      else if (rate_code == acq_config_pkg::RATE_CODE_FEATURES)
         next_rate = acq_config_pkg::RATE_FASTEST;
      else if (rate_code == acq_config_pkg::RATE_CODE_1P60)
         next_rate = acq_config_pkg::RATE_1P60_KHZ;
      else
         next_rate = acq_config_pkg::RATE_1P92_KHZ;
      // diagnostic result checks
      next_zs_alert = DIAG_RESULT_I.stuck_valid &&
         (DIAG_RESULT_I.zero_scale != acq_config_pkg::ZERO_SCALE_EXPECT);
      next_fs_alert = DIAG_RESULT_I.stuck_valid &&
         (DIAG_RESULT_I.full_scale != acq_config_pkg::FULL_SCALE_EXPECT);
      next_high_alert = DIAG_RESULT_I.accuracy_valid &&
                        DIAG_RESULT_I.accuracy_high_trip;
      next_low_alert = DIAG_RESULT_I.accuracy_valid &&
                       DIAG_RESULT_I.accuracy_low_trip;
   end

   // sequencer state and registered outputs
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         state <= ST_IDLE;
         SETTLE_DONE_O <= 1'b0;
         HIGH_VOLTAGE_CHARGE_PUMP_REFRESH_O <= 1'b0;
         THERMISTOR_BIAS_OUTPUT_ON_O <= 1'b0;
         AUX_ABS_REFERENCE_O <= '0;
         CALIBRATION_APPLY_O <= 1'b0;
         OVERSAMPLE_RATE_O <= acq_config_pkg::RATE_FASTEST;
         ADC_STUCK_DIAG_RUN_O <= 1'b0;
         COMPARATOR_ACCURACY_DIAG_RUN_O <= 1'b0;
         ADC_ZERO_SCALE_ALERT_O <= 1'b0;
         ADC_FULL_SCALE_ALERT_O <= 1'b0;
         COMPARATOR_ACCURACY_HIGH_ALERT_O <= 1'b0;
         COMPARATOR_ACCURACY_LOW_ALERT_O <= 1'b0;
      end
      else if (CE_I)
      begin
         state <= next_state;
         SETTLE_DONE_O <= next_settle_done;
         HIGH_VOLTAGE_CHARGE_PUMP_REFRESH_O <= next_refresh;
         THERMISTOR_BIAS_OUTPUT_ON_O <= next_bias_on;
         AUX_ABS_REFERENCE_O <= next_abs_ref;
         CALIBRATION_APPLY_O <=
            acquisition_config[acq_config_pkg::CAL_APPLY_BIT];
         OVERSAMPLE_RATE_O <= next_rate;
         ADC_STUCK_DIAG_RUN_O <= next_stuck_run;
         COMPARATOR_ACCURACY_DIAG_RUN_O <= next_acc_run;
         ADC_ZERO_SCALE_ALERT_O <= next_zs_alert;
         ADC_FULL_SCALE_ALERT_O <= next_fs_alert;
         COMPARATOR_ACCURACY_HIGH_ALERT_O <= next_high_alert;
         COMPARATOR_ACCURACY_LOW_ALERT_O <= next_low_alert;
      end
   end

   // checks on the steering outputs
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   a_ref_io_masked: assert property (
      CE_I && AUX_PIN_IO_MODE_ENABLE_I[0] |=> !AUX_ABS_REFERENCE_O[0])
      else $error("io mode channel kept absolute reference");
   a_ref_readback: assert property (
      CE_I && REG_REQ_I.wr &&
      REG_REQ_I.addr == acq_config_pkg::AUX_REFERENCE_CONTROL_ADDR ##1
      CE_I && REG_REQ_I.rd && !REG_REQ_I.wr &&
      REG_REQ_I.addr == acq_config_pkg::AUX_REFERENCE_CONTROL_ADDR |=>
      REG_RDATA_O == ($past(REG_REQ_I.wdata, 2) &
                      acq_config_pkg::REF_CONTROL_MASK))
      else $error("reference control readback differs from write");
   a_settle_zero_fast: assert property (
      CE_I && state == ST_IDLE && SCAN_REQ_I &&
      aux_settle_time == acq_config_pkg::REG_RESET ##1 CE_I [*3] |=>
      $past(SETTLE_DONE_O, 1) || SETTLE_DONE_O || state == ST_CONVERT)
      else $error("zero settle count did not finish at once");
   a_settle_not_idle: assert property (
      state == ST_IDLE |=> !SETTLE_DONE_O)
      else $error("settle done without a scan");
   a_refresh_settle: assert property (
      CE_I && state == ST_SETTLE && timer_busy && !OTHER_MEAS_ACTIVE_I |=>
      HIGH_VOLTAGE_CHARGE_PUMP_REFRESH_O)
      else $error("no charge pump refresh while settling");
   a_refresh_blocked: assert property (
      CE_I && OTHER_MEAS_ACTIVE_I |=> !HIGH_VOLTAGE_CHARGE_PUMP_REFRESH_O)
      else $error("refresh during another measurement");
   a_stuck_run: assert property (
      CE_I && state == ST_CONVERT && SEQ_END_I &&
      acquisition_config[acq_config_pkg::STUCK_DIAG_BIT] |=>
      ADC_STUCK_DIAG_RUN_O == $past(uses_adc))
      else $error("stuck diagnostic launch wrong");
   a_zero_alert: assert property (
      CE_I && DIAG_RESULT_I.stuck_valid &&
      DIAG_RESULT_I.zero_scale != acq_config_pkg::ZERO_SCALE_EXPECT |=>
      ADC_ZERO_SCALE_ALERT_O)
      else $error("zero-scale fault not reported");
   a_full_quiet: assert property (
      CE_I && DIAG_RESULT_I.full_scale == acq_config_pkg::FULL_SCALE_EXPECT
      |=> !ADC_FULL_SCALE_ALERT_O)
      else $error("full-scale alert on good result");
   a_cal_follows: assert property (
      CE_I && !acquisition_config[acq_config_pkg::CAL_APPLY_BIT] |=>
      !CALIBRATION_APPLY_O)
      else $error("calibration applied while disabled");
   a_acc_run: assert property (
      CE_I && state == ST_CONVERT && SEQ_END_I &&
      !acquisition_config[acq_config_pkg::ACCURACY_DIAG_BIT] |=>
      !COMPARATOR_ACCURACY_DIAG_RUN_O)
      else $error("accuracy diagnostic ran while disabled");
   a_acc_alerts: assert property (
      CE_I && DIAG_RESULT_I.accuracy_valid |=>
      COMPARATOR_ACCURACY_HIGH_ALERT_O ==
      $past(DIAG_RESULT_I.accuracy_high_trip) &&
      COMPARATOR_ACCURACY_LOW_ALERT_O ==
      $past(DIAG_RESULT_I.accuracy_low_trip))
      else $error("accuracy alert mismatch");
   a_rate_no_ovs: assert property (
      CE_I && OVERSAMPLE_COUNT_I == acq_config_pkg::OVERSAMPLE_OFF |=>
      OVERSAMPLE_RATE_O == acq_config_pkg::RATE_FASTEST)
      else $error("rate applied without oversampling");
   a_bias_manual: assert property (
      CE_I && bias_mode == acq_config_pkg::BIAS_MODE_OFF [*2] |->
      !THERMISTOR_BIAS_OUTPUT_ON_O)
      else $error("bias on in manual off mode");
   a_bias_auto_idle: assert property (
      CE_I && !bias_mode[1] && state == ST_IDLE && !SCAN_REQ_I |=>
      !THERMISTOR_BIAS_OUTPUT_ON_O)
      else $error("auto bias on outside acquisition");

endmodule

`default_nettype wire

// >>> dv/reg_host.sv
// host model: issues writes and reads on the block's register port
// assumes callers run in the clk_i domain and step after a rising edge
`timescale 1ns/1ps
`default_nettype none

module reg_host
(
   input wire logic clk_i,
   input wire logic rvalid_i,
   input wire logic [15:0] rdata_i,
   output var acq_config_pkg::reg_req_type req_o
);
   initial req_o = '0;

   // write strobe for exactly one taken edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      req_o <= '{1'b1, 1'b0, a, d};
      @(posedge clk_i);
      req_o <= '0;
   endtask

   // read strobe; data is taken with the valid pulse that follows
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk_i);
      req_o <= '0;
      #1;
      d = rvalid_i ? rdata_i : 16'hXXXX;
   endtask
endmodule
`default_nettype wire

// >>> dv/acquisition_config_control_tb.sv
// testbench: register, scan and diagnostic sequences with checks
// assumes the host model drives the register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module acquisition_config_control_tb;
   localparam int STEP = 4;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic scan_req = 1'b0;
   logic seq_end = 1'b0;
   logic other = 1'b0;
   logic [2:0] cfg = 3'h0;
   logic [2:0] ovs = 3'h0;
   logic [5:0] iom = 6'h00;
   logic [15:0] rdata, d;
   logic [5:0] absref;
   logic rvalid, sdone, pump, bias, cal, srun, crun, zs, fs, ah, al;
   acq_config_pkg::reg_req_type req;
   acq_config_pkg::diag_result_type diag = '0;
   acq_config_pkg::rate_type rate, er;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   int dt;
   logic sr, cr, pu;

   reg_host host (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata),
      .req_o(req));

   acquisition_config_control #(.STEP_CYCLES(STEP)) dut (.CLK_I(clk),
      .RESETN_I(rstn), .CE_I(ce), .REG_REQ_I(req), .REG_RDATA_O(rdata),
      .REG_RVALID_O(rvalid), .SCAN_REQ_I(scan_req),
      .SCAN_SEQUENCE_CONFIG_I(cfg), .SEQ_END_I(seq_end),
      .OTHER_MEAS_ACTIVE_I(other), .AUX_PIN_IO_MODE_ENABLE_I(iom),
      .OVERSAMPLE_COUNT_I(ovs), .DIAG_RESULT_I(diag),
      .AUX_ABS_REFERENCE_O(absref), .SETTLE_DONE_O(sdone),
      .HIGH_VOLTAGE_CHARGE_PUMP_REFRESH_O(pump),
      .THERMISTOR_BIAS_OUTPUT_ON_O(bias), .CALIBRATION_APPLY_O(cal),
      .OVERSAMPLE_RATE_O(rate), .ADC_STUCK_DIAG_RUN_O(srun),
      .COMPARATOR_ACCURACY_DIAG_RUN_O(crun), .ADC_ZERO_SCALE_ALERT_O(zs),
      .ADC_FULL_SCALE_ALERT_O(fs), .COMPARATOR_ACCURACY_HIGH_ALERT_O(ah),
      .COMPARATOR_ACCURACY_LOW_ALERT_O(al));

   // clock, 10 ns period
   initial
   begin
      forever #5 clk = ~clk;
   end

   // cycle ceiling against hangs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   // counts and verdict
   task automatic conclude();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // let a write reach the outputs
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   // one scan: request, settling, sequence end with config c
   task automatic scan(input logic [2:0] c);
      dt = 0;
      pu = 1'b0;
      @(posedge clk);
      scan_req <= 1'b1;
      @(posedge clk);
      scan_req <= 1'b0;
      #1;
      while (sdone !== 1'b1 && dt < 100)
      begin
         @(posedge clk);
         #1;
         dt++;
         pu = pu | (pump === 1'b1);
         if (dt == 1)
            `CHK(bias, 1'b1)
      end
      @(posedge clk);
      cfg <= c;
      seq_end <= 1'b1;
      @(posedge clk);
      seq_end <= 1'b0;
      #1;
      sr = srun;
      cr = crun;
      settle();
      `CHK(bias, 1'b0)
   endtask

   // one diagnostic result and the alerts it must raise
   task automatic diag_chk(input logic [11:0] z, input logic [11:0] f,
      input logic h, input logic l, input logic [3:0] e);
      @(posedge clk);
      diag <= '{1'b1, z, f, 1'b1, h, l};
      @(posedge clk);
      diag <= '0;
      #1;
      `CHK({zs, fs, ah, al}, e)
   endtask

   // main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      host.rd(8'h60, d); `CHK(d, 16'h0000)
      host.rd(8'h61, d); `CHK(d, 16'h0000)
      host.rd(8'h62, d); `CHK(d, 16'h0000)
      host.wr(8'h61, 16'hFFFF);
      host.rd(8'h61, d); `CHK(d, 16'h03FF)
      host.wr(8'h62, 16'hFFFF);
      host.rd(8'h62, d); `CHK(d, 16'hFE00)
      host.wr(8'h70, 16'hFFFF);
      host.rd(8'h70, d); `CHK(d, 16'h0000)
      host.wr(8'h60, 16'hFFD5);
      settle(); `CHK(absref, 6'h15)
      @(posedge clk);
      iom <= 6'h3F;
      host.rd(8'h60, d); `CHK(d, 16'h0015)
      `CHK(absref, 6'h00)
      @(posedge clk);
      iom <= 6'h00;
      $display("test registers done");
      ovs <= 3'h1;
      for (int r = 0; r < 4; r++)
      begin
         host.wr(8'h62, {3'b010, r[1:0], 2'b10, 9'h000});
         settle();
         er = (r == 0) ? acq_config_pkg::RATE_FASTEST :
            (r == 1) ? acq_config_pkg::RATE_1P60_KHZ :
            acq_config_pkg::RATE_1P92_KHZ;
         `CHK(rate, er)
         `CHK(cal, 1'b1)
         `CHK(bias, 1'b0)
      end
      @(posedge clk);
      ovs <= 3'h0;
      settle(); `CHK(rate, acq_config_pkg::RATE_FASTEST)
      host.wr(8'h62, 16'h0600);
      settle(); `CHK(bias, 1'b1)
      `CHK(cal, 1'b0)
      $display("test config done");
      host.wr(8'h61, 16'h0003);
      host.wr(8'h62, 16'hA000);
      for (int c = 0; c < 4; c++)
      begin
         // last pass: zero settle count, adc-only config
         if (c == 3)
            host.wr(8'h61, 16'h0000);
         @(posedge clk);
         other <= (c == 2);
         scan(c[2:0]);
         if (c == 3)
            `CHK(dt, 2)
         else
            `CHK(dt >= 3 * STEP && dt <= 3 * STEP + 3, 1'b1)
         `CHK(sr, c != 2)
         `CHK(cr, c == 1 || c == 2)
         `CHK(pu, c != 2)
      end
      $display("test scans done");
      diag_chk(12'h001, 12'hFFF, 1'b1, 1'b0, 4'b1010);
      diag_chk(12'h000, 12'hFFE, 1'b0, 1'b1, 4'b0101);
      diag_chk(12'h000, 12'hFFF, 1'b0, 1'b0, 4'b0000);
      $display("test diagnostics done");
      // a write while the clock enable is low must not land
      @(posedge clk);
      ce <= 1'b0;
      host.wr(8'h61, 16'h0155);
      @(posedge clk);
      ce <= 1'b1;
      host.rd(8'h61, d); `CHK(d, 16'h0000)
      // reset in mid-run clears the registers again
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      host.rd(8'h60, d); `CHK(d, 16'h0000)
      `CHK(bias, 1'b0)
      $display("test freeze and reset done");
      conclude();
   end
endmodule
`default_nettype wire
